//--- hdl/ccs_scan_sequencer.sv
/*
 * Readout sequencer of one cascadable linear image sensor die.
 * Assumes the scan controller drives shiftClk, globalStartPulse and the
 * chain start synchronously to mclk, far slower than mclk, and that the
 * integration side writes the per-cell hold memory through holdWr*.
 */
// Operation
// - Scan begins only after global start is sampled on a shift clock fall.
// - First-die strap high: lead die with 55-clock delay; low: follower.
// - Only the lead die emits 110 inactive slots over 55 clocks.
// - All dies run initialization together for 55 clocks after start.
// - Lead die presents its first active pixel on the 56th clock.
// - A follower waits after initialization for a chain start pulse.
// - 1200 dpi: done pulse at the 389th clock fall, 20 pixels early.
// - Each done pulse drives the next die's chain start input.
// - Output amplifier enabled only while own pixels are read out.
// - Mode strap low selects 600 dpi, high selects 1200 dpi.
// - 1200 dpi: all 688 pixels are output one by one.
// - 600 dpi: adjacent pairs are merged into 344 outputs.
// - 600 dpi: half the scan register is idle, readout halves.
// - Both modes run from the same shift clock rate.
// - Readout runs while integration writes held cells.
// - Two slots are presented for every shift clock cycle of lead-die init and of scan.
`timescale 1ns/1ps

module ccs_scan_sequencer (
  input  wire logic                     mclk,             // System clock
  input  wire logic                     reset_n,          // Async reset
  input  wire logic                     shiftClk,         // Scan clock pin
  input  wire logic                     globalStartPulse, // Global start
  input  wire logic                     chainStartIn,     // From prior die
  input  wire logic                     firstDieStrap,    // High: lead die
  input  wire logic                     dpiModePin,       // High: 1200 dpi
  input  wire logic                     holdWrEn,         // Hold cell write
  input  wire logic [ccs_pkg::IDX_W-1:0] holdWrAddr,      // Cell number
  input  wire logic [ccs_pkg::PIX_W-1:0] holdWrData,      // Integrated level
  output logic                          videoValid,       // Slot available
  input  wire logic                     videoReady,       // Receiver takes
  output ccs_pkg::ccs_slot_t            videoWord,        // Video slot
  output logic                          chainDone,        // End-of-scan
  output logic                          ampEnable         // Amplifier on
);

  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Scan length in shift clocks; the unused half of the register is idle
  function automatic logic [ccs_pkg::CNT_W-1:0] scanLen(input logic hi);
    scanLen = hi ? ccs_pkg::SCAN_CLKS_HI : ccs_pkg::SCAN_CLKS_LO;
  endfunction : scanLen

  // Scan index at which the end-of-scan level rises
  function automatic logic [ccs_pkg::CNT_W-1:0] doneIdx(input logic hi);
    doneIdx = scanLen(hi) - ccs_pkg::DONE_LEAD_CLKS - 9'h001;
  endfunction : doneIdx

  // ******************************************************************
  // Hold cells
  // ******************************************************************
  logic [ccs_pkg::PIX_W-1:0] holdMem [ccs_pkg::PIXEL_COUNT];

  // Integration writes while readout reads, no arbitration needed
  always_ff @(posedge mclk) begin
    if (holdWrEn) begin
      holdMem[holdWrAddr] <= holdWrData;
    end
  end

  // Level of one output slot; 600 dpi sums a cell pair
  function automatic logic [ccs_pkg::LVL_W-1:0] slotLevel(
    input logic hi, input logic [ccs_pkg::IDX_W-1:0] idx);
    logic [ccs_pkg::IDX_W-1:0] even;
    even = {idx[ccs_pkg::IDX_W-2:0], 1'b0};
    if (hi) begin
      slotLevel = {1'b0, holdMem[idx]};
    end else begin
      slotLevel = {1'b0, holdMem[even]} +
                  {1'b0, holdMem[even | 10'h001]};
    end
  endfunction : slotLevel

  // ******************************************************************
  // Scan sequencer
  // ******************************************************************
  ccs_pkg::ccs_state_t       state_r, state_nxt;
  logic [ccs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic                      leadDie_r, leadDie_nxt;
  logic                      hiRes_r, hiRes_nxt;
  logic                      shiftPrev_r;
  logic                      done_r, done_nxt;
  logic                      amp_r, amp_nxt;
  logic                      fall;
  logic                      emit;
  logic                      emitAct;
  logic [ccs_pkg::IDX_W-1:0] emitBase;

  // Sequencer registers other than shiftPrev_r load on the fall, like the die's own scan register
  assign fall = shiftPrev_r & ~shiftClk;

  // Next state; a global start restarts the scan from any state
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    leadDie_nxt = leadDie_r;
    hiRes_nxt   = hiRes_r;
    done_nxt    = done_r;
    emit        = 1'b0;
    emitAct     = 1'b0;
    emitBase    = '0;
    if (fall) begin
      done_nxt = 1'b0; // Done stands for one shift clock
      if (globalStartPulse) begin
        state_nxt   = ccs_pkg::SEQ_INIT;
        cnt_nxt     = '0;
        leadDie_nxt = firstDieStrap;
        hiRes_nxt   = dpiModePin;
      end else begin
        case (state_r)
          ccs_pkg::SEQ_INIT: begin
            // Every die initializes, only the lead die shows slots
            cnt_nxt  = cnt_r + 9'h001;
            emit     = leadDie_r;
            emitBase = ccs_pkg::IDX_W'({cnt_r, 1'b0});
            if (cnt_nxt == ccs_pkg::INIT_LAST) begin
              cnt_nxt   = '0;
              state_nxt = leadDie_r ? ccs_pkg::SEQ_SCAN
                                    : ccs_pkg::SEQ_WAIT_CHAIN;
            end
          end
          ccs_pkg::SEQ_WAIT_CHAIN: begin
            if (chainStartIn) begin
              state_nxt = ccs_pkg::SEQ_LEAD_IN;
              cnt_nxt   = '0;
            end
          end
          ccs_pkg::SEQ_LEAD_IN: begin
            // Closes the gap left by the predecessor's early done pulse
            cnt_nxt = cnt_r + 9'h001;
            if (cnt_nxt == ccs_pkg::CHAIN_LEAD_IN) begin
              state_nxt = ccs_pkg::SEQ_SCAN;
              cnt_nxt   = '0;
            end
          end
          ccs_pkg::SEQ_SCAN: begin
            emit     = 1'b1;
            emitAct  = 1'b1;
            emitBase = ccs_pkg::IDX_W'({cnt_r, 1'b0});
            cnt_nxt  = cnt_r + 9'h001; // Same clock in both modes
            if (cnt_r == doneIdx(hiRes_r)) begin
              done_nxt = 1'b1;
            end
            if (cnt_nxt == scanLen(hiRes_r)) begin
              state_nxt = ccs_pkg::SEQ_IDLE;
              cnt_nxt   = '0;
            end
          end
          default: begin
            state_nxt = ccs_pkg::SEQ_IDLE;
          end
        endcase
      end
    end
    amp_nxt = (state_nxt == ccs_pkg::SEQ_SCAN);
  end

  // Sequencer registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= ccs_pkg::SEQ_IDLE;
      cnt_r       <= '0;
      leadDie_r   <= 1'b0;
      hiRes_r     <= 1'b0;
      shiftPrev_r <= 1'b0;
      done_r      <= 1'b0;
      amp_r       <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      leadDie_r   <= leadDie_nxt;
      hiRes_r     <= hiRes_nxt;
      shiftPrev_r <= shiftClk;
      done_r      <= done_nxt;
      amp_r       <= amp_nxt;
    end
  end

  assign chainDone = done_r;
  assign ampEnable = amp_r;

  // ******************************************************************
  // Slot emitter
  // ******************************************************************
  logic [1:0]                pend_r, pend_nxt;
  logic [ccs_pkg::IDX_W-1:0] pendIdx_r, pendIdx_nxt;
  logic                      pendAct_r, pendAct_nxt;
  logic                      push;
  logic                      bufInReady;
  ccs_pkg::ccs_slot_t        pushWord;

  // Two slots per fall go out on consecutive mclk cycles; a stall
  // of nearly two shift clocks can overwrite the pending pair
  always_comb begin
    pend_nxt    = pend_r;
    pendIdx_nxt = pendIdx_r;
    pendAct_nxt = pendAct_r;
    push        = (pend_r != 2'b00) && bufInReady;
    pushWord.active = pendAct_r;
    pushWord.index  = pendIdx_r;
    pushWord.level  = pendAct_r ? slotLevel(hiRes_r, pendIdx_r) : '0;
    if (push) begin
      pend_nxt    = pend_r - 2'b01;
      pendIdx_nxt = pendIdx_r + 10'h001;
    end
    if (emit) begin
      pend_nxt    = ccs_pkg::SLOT_PAIR;
      pendIdx_nxt = emitBase;
      pendAct_nxt = emitAct;
    end
  end

  // Emitter registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r    <= 2'b00;
      pendIdx_r <= '0;
      pendAct_r <= 1'b0;
    end else begin
      pend_r    <= pend_nxt;
      pendIdx_r <= pendIdx_nxt;
      pendAct_r <= pendAct_nxt;
    end
  end

  // ******************************************************************
  // Two-entry output buffer
  // ******************************************************************
  ccs_pkg::ccs_slot_t slotBuf_r [2];
  logic               wrPtr_r, wrPtr_nxt;
  logic               rdPtr_r, rdPtr_nxt;
  logic [1:0]         fill_r, fill_nxt;
  logic               pop;

  // Ready only while a slot is free, so the emitter holds its words
  always_comb begin
    bufInReady = (fill_r != 2'b10);
    pop        = (fill_r != 2'b00) && videoReady;
    wrPtr_nxt  = push ? ~wrPtr_r : wrPtr_r;
    rdPtr_nxt  = pop ? ~rdPtr_r : rdPtr_r;
    fill_nxt   = fill_r + {1'b0, push} - {1'b0, pop};
  end

  // Buffer registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slotBuf_r[0] <= '0;
      slotBuf_r[1] <= '0;
      wrPtr_r      <= 1'b0;
      rdPtr_r      <= 1'b0;
      fill_r       <= 2'b00;
    end else begin
      if (push) begin
        slotBuf_r[wrPtr_r] <= pushWord;
      end
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      fill_r  <= fill_nxt;
    end
  end

  assign videoValid = (fill_r != 2'b00);
  assign videoWord  = slotBuf_r[rdPtr_r];

  // ******************************************************************
  // Assertions
  // ******************************************************************
  sequence seqStart;
    fall && globalStartPulse;
  endsequence

  sequence seqInitEnd;
    state_r == ccs_pkg::SEQ_INIT && fall && !globalStartPulse &&
    cnt_r == ccs_pkg::INIT_LAST - 9'h001;
  endsequence

  AST_START_SAMPLED: assert property (@(posedge mclk) disable iff (!reset_n)
    seqStart |=> state_r == ccs_pkg::SEQ_INIT && cnt_r == '0)
    else $error("start not taken on shift clock fall");

  AST_NO_START_WITHOUT_FALL: assert property (@(posedge mclk)
    disable iff (!reset_n)
    state_r == ccs_pkg::SEQ_IDLE && !fall |=> state_r == ccs_pkg::SEQ_IDLE)
    else $error("scan began without a sampled start");

  AST_INIT_EXIT: assert property (@(posedge mclk) disable iff (!reset_n)
    seqInitEnd |=> (leadDie_r ? state_r == ccs_pkg::SEQ_SCAN
                              : state_r == ccs_pkg::SEQ_WAIT_CHAIN))
    else $error("wrong state after initialization");

  AST_FOLLOWER_WAITS: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r == ccs_pkg::SEQ_WAIT_CHAIN && !(fall && chainStartIn) &&
    !(fall && globalStartPulse) |=> state_r == ccs_pkg::SEQ_WAIT_CHAIN)
    else $error("follower left wait without chain start");

  AST_DONE_POINT: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(done_r) |-> $past(state_r) == ccs_pkg::SEQ_SCAN &&
                      $past(cnt_r) == doneIdx(hiRes_r))
    else $error("done pulse at the wrong scan clock");

  AST_AMP_SCAN_ONLY: assert property (@(posedge mclk) disable iff (!reset_n)
    state_r != ccs_pkg::SEQ_SCAN |-> !ampEnable)
    else $error("amplifier on outside own readout");

  AST_TWO_SLOTS: assert property (@(posedge mclk) disable iff (!reset_n)
    emit ##1 (bufInReady && !emit)[*2] |=> pend_r == 2'b00)
    else $error("pair of slots not delivered");

  AST_DUMMY_LEAD_ONLY: assert property (@(posedge mclk) disable iff (!reset_n)
    push && !pushWord.active |-> leadDie_r &&
    pushWord.index < ccs_pkg::IDX_W'(ccs_pkg::INACTIVE_SLOTS))
    else $error("inactive slot from follower or out of range");

  AST_SLOT_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
    push && pushWord.active |-> pushWord.index <
      (hiRes_r ? ccs_pkg::IDX_W'(ccs_pkg::PIXEL_COUNT)
               : ccs_pkg::IDX_W'(ccs_pkg::MERGED_COUNT)))
    else $error("active slot index beyond mode length");

  AST_BUF_FULL: assert property (@(posedge mclk) disable iff (!reset_n)
    fill_r == 2'b10 |-> !push && videoValid)
    else $error("write into a full buffer");

endmodule : ccs_scan_sequencer

//--- hdl/ccs_pkg.sv
/*
 * Constants and carrier types of the cascade scan sequencer.
 * Assumes a single 40 MHz system clock; the scan shift clock arrives as
 * an ordinary synchronous input.
 */
package ccs_pkg;

  // ******************************************************************
  // Geometry and timing
  // ******************************************************************
  localparam int unsigned SYS_CLK_HZ     = 40_000_000;
  localparam int unsigned PIXEL_COUNT    = 688;   // Active cells per die
  localparam int unsigned MERGED_COUNT   = 344;   // Outputs in 600 dpi
  localparam int unsigned SLOTS_PER_CLK  = 2;     // Slots per shift clock
  localparam int unsigned INIT_CLKS      = 55;    // Pre-scan initialization
  localparam int unsigned INACTIVE_SLOTS = 110;   // Lead die dummy slots
  localparam int unsigned DONE_LEAD_PIX  = 20;    // Done pulse lead, pixels
  localparam int unsigned FIRST_PIX_CLK  = 56;    // Lead die first pixel
  localparam int unsigned DONE_CLK_HI    = 389;   // Done clock, 1200 dpi

  localparam int unsigned IDX_W = 10;
  localparam int unsigned PIX_W = 8;
  localparam int unsigned LVL_W = 9;
  localparam int unsigned CNT_W = 9;

  // Done pulse stands this many shift clocks before the last one
  localparam logic [CNT_W-1:0] DONE_LEAD_CLKS =
    CNT_W'(DONE_LEAD_PIX / SLOTS_PER_CLK);
  // Successor samples the done level one edge late, so it needs one
  // edge fewer of lead-in before its own first pixel
  localparam logic [CNT_W-1:0] CHAIN_LEAD_IN = DONE_LEAD_CLKS - 9'h001;
  localparam logic [CNT_W-1:0] INIT_LAST     = CNT_W'(INIT_CLKS);
  localparam logic [CNT_W-1:0] SCAN_CLKS_HI  =
    CNT_W'(PIXEL_COUNT / SLOTS_PER_CLK);
  localparam logic [CNT_W-1:0] SCAN_CLKS_LO  =
    CNT_W'(MERGED_COUNT / SLOTS_PER_CLK);
  localparam logic [1:0]       SLOT_PAIR     = 2'(SLOTS_PER_CLK);

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_INIT, SEQ_WAIT_CHAIN, SEQ_LEAD_IN, SEQ_SCAN
  } ccs_state_t;

  typedef struct packed {
    logic             active;  // Zero for the lead die's dummy slots
    logic [IDX_W-1:0] index;   // Slot number within its phase
    logic [LVL_W-1:0] level;   // Held level, or sum of a merged pair
  } ccs_slot_t;

endpackage : ccs_pkg

//--- testbench/ccs_scan_ctrl_model.sv
/*
 * Far-side model: scan controller making the shift clock and global
 * start, the preceding die's done pulse, and a stalling video receiver.
 * Assumes mclk at 40 MHz; everything here changes on its falling edge.
 */
`timescale 1ns/1ps

module ccs_scan_ctrl_model #(
  parameter int HALF = 14                 // mclk per shift half period
) (
  input  wire logic mclk,             // System clock
  input  wire logic reset_n,          // Async reset
  input  wire logic runClk,           // Shift clock runs while high
  input  wire logic startReq,         // Ask for one global start
  input  wire logic chainReq,         // Ask for one chain start
  input  wire logic stallEn,          // Receiver stalls now and then
  output logic      shiftClk,         // Scan shift clock
  output logic      globalStartPulse, // Global start to every die
  output logic      chainStartIn,     // Predecessor done pulse
  output logic      videoReady        // Receiver takes a slot
);
  int         halfCnt;
  logic       startArm;
  logic       chainArm;
  logic [2:0] stallCnt;

  // ******************************************************************
  // Clock, start pulses and receiver
  // ******************************************************************
  // Defined levels before the first edge
  initial begin
    shiftClk = 1'h1;
    globalStartPulse = 1'h0;
    chainStartIn = 1'h0;
    videoReady = 1'h1;
  end

  // Pulses rise with the shift clock and drop mid low phase, so exactly
  // one falling edge sees them; a longer pulse would load two starts
  always @(negedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shiftClk <= 1'h1;
      globalStartPulse <= 1'h0;
      chainStartIn <= 1'h0;
      videoReady <= 1'h1;
      halfCnt <= 0;
      startArm <= 1'h0;
      chainArm <= 1'h0;
      stallCnt <= 3'h0;
    end else begin
      if (startReq) startArm <= 1'h1;
      if (chainReq) chainArm <= 1'h1;
      stallCnt <= stallCnt + 3'h1;
      videoReady <= !(stallEn && stallCnt < 3'h3);  // Short stalls only
      if (!runClk) begin
        shiftClk <= 1'h1;                  // Stands still between frames
        halfCnt <= 0;
      end else if (halfCnt == HALF - 1) begin
        halfCnt <= 0;
        shiftClk <= !shiftClk;
        if (!shiftClk) begin
          globalStartPulse <= startArm || startReq;
          chainStartIn <= chainArm || chainReq;
          startArm <= 1'h0;
          chainArm <= 1'h0;
        end
      end else begin
        halfCnt <= halfCnt + 1;
        if (!shiftClk && halfCnt == HALF / 2) begin
          globalStartPulse <= 1'h0;
          chainStartIn <= 1'h0;
        end
      end
    end
  end
endmodule : ccs_scan_ctrl_model

//--- testbench/test_ccs_scan_sequencer.sv
/*
 * Self-checking bench of the scan sequencer: lead die in both modes,
 * then a follower die started by a chain pulse.
 * Assumes ccs_pkg and the far-side model are compiled first.
 */
`timescale 1ns/1ps

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("[ERR] %s expected %h seen %h", nm, e, g); n_mismatch++; end end

module test_ccs_scan_sequencer;
  logic                      mclk = 1'h0;
  logic                      reset_n = 1'h0;
  logic                      runClk = 1'h0, startReq = 1'h0;
  logic                      chainReq = 1'h0, stallEn = 1'h0;
  logic                      firstDieStrap = 1'h1, dpiModePin = 1'h1;
  logic                      holdWrEn = 1'h0;
  logic [ccs_pkg::IDX_W-1:0] holdWrAddr = 10'h000;
  logic [ccs_pkg::PIX_W-1:0] holdWrData = 8'h00;
  logic                      shiftClk, globalStartPulse, chainStartIn;
  logic                      videoReady, videoValid, chainDone, ampEnable;
  ccs_pkg::ccs_slot_t        videoWord;
  ccs_pkg::ccs_slot_t        got[$];
  logic [7:0]                mem[688];
  logic                      shPrev = 1'h0, ampPrev = 1'h0, donePrev = 1'h0;
  int                        fallCnt = 0, chainFall = 0, ampRise = -1;
  int                        doneRise = -1, doneFall = -1, cycles = 0;
  int                        n_mismatch = 0, comparisons = 0;

  always #12.5 mclk = ~mclk;

  ccs_scan_sequencer DUT (.mclk(mclk), .reset_n(reset_n),
    .shiftClk(shiftClk), .globalStartPulse(globalStartPulse),
    .chainStartIn(chainStartIn), .firstDieStrap(firstDieStrap),
    .dpiModePin(dpiModePin), .holdWrEn(holdWrEn), .holdWrAddr(holdWrAddr),
    .holdWrData(holdWrData), .videoValid(videoValid),
    .videoReady(videoReady), .videoWord(videoWord),
    .chainDone(chainDone), .ampEnable(ampEnable));

  ccs_scan_ctrl_model #(.HALF(14)) farSide (.mclk(mclk), .reset_n(reset_n),
    .runClk(runClk), .startReq(startReq), .chainReq(chainReq),
    .stallEn(stallEn), .shiftClk(shiftClk),
    .globalStartPulse(globalStartPulse), .chainStartIn(chainStartIn),
    .videoReady(videoReady));

  // ******************************************************************
  // Monitor: falls are numbered from the start fall, which is fall 0
  // ******************************************************************
  always @(posedge mclk) begin
    shPrev <= shiftClk;
    ampPrev <= ampEnable;
    donePrev <= chainDone;
    if (shPrev && !shiftClk) begin
      fallCnt <= globalStartPulse ? 0 : fallCnt + 1;
      if (chainStartIn) chainFall <= fallCnt + 1;
    end
    if (videoValid && videoReady) got.push_back(videoWord);
    if (ampEnable && !ampPrev) ampRise <= fallCnt;
    if (chainDone && !donePrev) doneRise <= fallCnt;
    if (!chainDone && donePrev) doneFall <= fallCnt;
    cycles++;
    if (cycles == 60000) begin      // About twice the expected run
      n_mismatch++;
      complete_run();
    end
  end

  // ******************************************************************
  // Helpers
  // ******************************************************************
  task automatic wait_falls(input int n);
    for (int k = 0; k < 20000 && fallCnt < n; k++) @(negedge mclk);
  endtask : wait_falls

  // Fills every hold cell, one write per cycle
  task automatic load_cells(input int s);
    for (int i = 0; i < 688; i++) begin
      mem[i] = 8'(i * s + 3);
      holdWrEn <= 1'h1;
      holdWrAddr <= 10'(i);
      holdWrData <= 8'(i * s + 3);
      @(negedge mclk);
    end
    holdWrEn <= 1'h0;
  endtask : load_cells

  // Fall counter parked far negative so only the start fall zeroes it
  task automatic begin_frame(input logic lead, input logic hi,
                             input logic st);
    @(negedge mclk);  // Lets a stop of the shift clock land first
    got.delete();
    ampRise = -1;
    doneRise = -1;
    doneFall = -1;
    fallCnt = -1000;
    firstDieStrap <= lead;
    dpiModePin <= hi;
    stallEn <= st;
    runClk <= 1'h1;
    startReq <= 1'h1;
    @(negedge mclk);
    startReq <= 1'h0;
    chainReq <= 1'h0;
    wait_falls(0);
  endtask : begin_frame

  task automatic check_stream(input logic lead, input logic hi);
    ccs_pkg::ccs_slot_t e;
    int                 nd, na, j;
    nd = lead ? 110 : 0;
    na = hi ? 688 : 344;
    `CHK("slot count", nd + na, got.size())
    for (int k = 0; k < got.size() && k < nd + na; k++) begin
      j = k - nd;
      if (k < nd) e = '{1'h0, 10'(k), 9'h000};
      else if (hi) e = '{1'h1, 10'(j), {1'h0, mem[j]}};
      else e = '{1'h1, 10'(j), 9'(mem[2*j]) + 9'(mem[2*j+1])};
      `CHK("slot", e, got[k])
    end
  endtask : check_stream

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  // Lead die, 1200 dpi; a chain pulse on the start fall must change nothing
  task automatic test_lead_hi;
    load_cells(5);
    chainReq <= 1'h1;
    begin_frame(1'h1, 1'h1, 1'h0);
    wait_falls(403);
    check_stream(1'h1, 1'h1);
    // Amplifier wakes as init ends, ready for the 56th clock's pixel
    `CHK("amp rise fall", 55, ampRise)
    `CHK("done rise fall", 389, doneRise)
    `CHK("done end fall", 390, doneFall)
    `CHK("amp off", 1'h0, ampEnable)
    runClk <= 1'h0;
    $display("test_lead_hi finished");
  endtask : test_lead_hi

  // Lead die, 600 dpi, same shift clock, receiver stalling
  task automatic test_lead_lo;
    load_cells(7);
    begin_frame(1'h1, 1'h0, 1'h1);
    wait_falls(231);
    check_stream(1'h1, 1'h0);
    `CHK("amp rise fall", 55, ampRise)
    `CHK("done rise fall", 217, doneRise)
    `CHK("amp off", 1'h0, ampEnable)
    runClk <= 1'h0;
    $display("test_lead_lo finished");
  endtask : test_lead_lo

  // Follower: quiet through init, then waits for the chain pulse
  task automatic test_follower;
    begin_frame(1'h0, 1'h1, 1'h1);
    load_cells(3);
    wait_falls(56);
    `CHK("follower quiet", 0, got.size())
    `CHK("follower amp", 1'h0, ampEnable)
    chainReq <= 1'h1;
    @(negedge mclk);
    chainReq <= 1'h0;
    wait_falls(60);
    wait_falls(chainFall + 357);
    check_stream(1'h0, 1'h1);
    // Lead-in ends on the 9th fall; first pixels go out on the 10th
    `CHK("amp rise fall", chainFall + 9, ampRise)
    `CHK("done rise fall", chainFall + 343, doneRise)
    `CHK("done end fall", chainFall + 344, doneFall)
    runClk <= 1'h0;
    $display("test_follower finished");
  endtask : test_follower

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (4) @(negedge mclk);
    reset_n <= 1'h1;
    @(negedge mclk);
    test_lead_hi();
    test_lead_lo();
    test_follower();
    complete_run();
  end
endmodule : test_ccs_scan_sequencer
